// [verilog/plsu_pkg.sv]
// Purpose: Constants and types for the address and load/store execution block
// Assumes: 32-bit data, 16 general registers, byte-addressed memory
// Notes: Register numbers 13 and 15 are the stack pointer and program counter
package plsu_pkg;
    localparam int DATA_W = 32;
    localparam logic [3:0] REG_STACK_POINTER = 4'hd;
    localparam logic [3:0] REG_PROGRAM_COUNTER = 4'hf;
    localparam logic [12:0] ADR_OFFSET_MAX = 13'h0fff;
    localparam logic [12:0] PLAIN_OFFSET_MAX = 13'h0fff;
    localparam logic [12:0] INDEX_OFFSET_MAX = 13'h00ff;
    localparam logic [12:0] NEG_OFFSET_MAX = 13'h00ff;
    localparam logic [12:0] PAIR_OFFSET_MAX = 13'h03fc;
    localparam logic [31:0] WORD_STEP = 32'h00000004;
    localparam logic [31:0] RESET_WORD = 32'h00000000;

    typedef enum logic [2:0] {
        PLSU_OP_NONE = 3'h0,
        PLSU_OP_ADDR = 3'h1,
        PLSU_OP_LOAD = 3'h2,
        PLSU_OP_STORE = 3'h3
    } plsu_op_t;

    typedef enum logic [2:0] {
        PLSU_SZ_WORD = 3'h0,
        PLSU_SZ_BYTE = 3'h1,
        PLSU_SZ_HALF = 3'h2,
        PLSU_SZ_SBYTE = 3'h3,
        PLSU_SZ_SHALF = 3'h4
    } plsu_size_t;

    typedef enum logic [1:0] {
        PLSU_IDX_PLAIN = 2'h0,
        PLSU_IDX_PRE = 2'h1,
        PLSU_IDX_POST = 2'h2
    } plsu_index_t;

    typedef enum logic [3:0] {
        PLSU_CC_EQ = 4'h0, PLSU_CC_NE = 4'h1, PLSU_CC_CS = 4'h2, PLSU_CC_CC = 4'h3,
        PLSU_CC_MI = 4'h4, PLSU_CC_PL = 4'h5, PLSU_CC_VS = 4'h6, PLSU_CC_VC = 4'h7,
        PLSU_CC_HI = 4'h8, PLSU_CC_LS = 4'h9, PLSU_CC_GE = 4'ha, PLSU_CC_LT = 4'hb,
        PLSU_CC_GT = 4'hc, PLSU_CC_LE = 4'hd, PLSU_CC_AL = 4'he
    } plsu_cond_t;

    typedef enum logic [2:0] {
        PLSU_ST_IDLE = 3'b000,
        PLSU_ST_FIRST = 3'b001,
        PLSU_ST_SECOND = 3'b011,
        PLSU_ST_DONE = 3'b010
    } plsu_state_t;
endpackage

// [verilog/plsu_core.sv]
// Purpose: Executes the PC-relative address operation and immediate-offset loads/stores
// Assumes: Memory answers each request with a ready pulse; one instruction at a time
// Notes: Register file reads are combinational on the read-data inputs
`timescale 1ns/1ps

module plsu_core (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Instruction request
    input wire logic INSTR_VALID,
    output logic INSTR_READY,
    input wire plsu_pkg::plsu_op_t OP,
    input wire plsu_pkg::plsu_size_t SIZE,
    input wire plsu_pkg::plsu_index_t INDEX_MODE,
    input wire plsu_pkg::plsu_cond_t COND,
    input wire logic TWO_WORD_TRANSFER_FORM,
    input wire logic OFFSET_SUBTRACT,
    input wire logic [12:0] OFFSET_MAG,
    input wire logic [3:0] TRANSFER_REGISTER,
    input wire logic [3:0] SECOND_TRANSFER_REGISTER,
    input wire logic [3:0] BASE_REGISTER,
    input wire logic [31:0] PROGRAM_COUNTER,
    // Operand values and flags
    input wire logic [31:0] BASE_VALUE,
    input wire logic [31:0] TRANSFER_VALUE,
    input wire logic [31:0] SECOND_VALUE,
    input wire logic FLAG_N,
    input wire logic FLAG_Z,
    input wire logic FLAG_C,
    input wire logic FLAG_V,
    // Register write-back
    output logic WB_VALID,
    output logic [3:0] WB_REG,
    output logic [31:0] WB_DATA,
    output logic BASE_WB_VALID,
    output logic [3:0] BASE_WB_REG,
    output logic [31:0] BASE_WB_DATA,
    // Completion
    output logic DONE,
    output logic UNSUPPORTED,
    output logic SKIPPED,
    // Data memory
    output logic MEM_REQ,
    output logic MEM_WRITE,
    output logic [31:0] MEM_ADDR,
    output logic [31:0] MEM_WDATA,
    output logic [3:0] MEM_BYTE_EN,
    input wire logic MEM_READY,
    input wire logic [31:0] MEM_RDATA
);
    import plsu_pkg::*;

    function automatic logic cond_pass(input plsu_cond_t c, input logic n, input logic z,
                                       input logic cy, input logic v);
        unique case (c)
            PLSU_CC_EQ: cond_pass = z;
            PLSU_CC_NE: cond_pass = !z;
            PLSU_CC_CS: cond_pass = cy;
            PLSU_CC_CC: cond_pass = !cy;
            PLSU_CC_MI: cond_pass = n;
            PLSU_CC_PL: cond_pass = !n;
            PLSU_CC_VS: cond_pass = v;
            PLSU_CC_VC: cond_pass = !v;
            PLSU_CC_HI: cond_pass = cy && !z;
            PLSU_CC_LS: cond_pass = !cy || z;
            PLSU_CC_GE: cond_pass = n == v;
            PLSU_CC_LT: cond_pass = n != v;
            PLSU_CC_GT: cond_pass = !z && (n == v);
            PLSU_CC_LE: cond_pass = z || (n != v);
            default: cond_pass = 1'b1;
        endcase
    endfunction

    // Byte lane placement, used for the strobes; store data is shifted separately
    function automatic logic [3:0] lane_mask(input plsu_size_t s, input logic [1:0] a);
        unique case (s)
            PLSU_SZ_BYTE, PLSU_SZ_SBYTE: lane_mask = 4'h1 << a;
            PLSU_SZ_HALF, PLSU_SZ_SHALF: lane_mask = a[1] ? 4'hc : 4'h3;
            default: lane_mask = 4'hf;
        endcase
    endfunction

    function automatic logic [31:0] extend_load(input plsu_size_t s, input logic [1:0] a,
                                                input logic [31:0] d);
        logic [7:0] b;
        logic [15:0] h;
        b = d[8*a +: 8];
        h = a[1] ? d[31:16] : d[15:0];
        unique case (s)
            PLSU_SZ_BYTE: extend_load = {24'h000000, b};
            PLSU_SZ_SBYTE: extend_load = {{24{b[7]}}, b};
            PLSU_SZ_HALF: extend_load = {16'h0000, h};
            PLSU_SZ_SHALF: extend_load = {{16{h[15]}}, h};
            default: extend_load = d;
        endcase
    endfunction

    plsu_state_t state, next_state;
    logic is_load, next_is_load;
    logic pair, next_pair;
    plsu_size_t size_q, next_size_q;
    logic [31:0] addr_q, next_addr_q;
    logic [31:0] data2_q, next_data2_q;
    logic [3:0] rt_q, next_rt_q;
    logic [3:0] rt2_q, next_rt2_q;
    logic [3:0] rn_q, next_rn_q;
    logic [31:0] wbase_q, next_wbase_q;
    logic do_wb_base, next_do_wb_base;
    logic wb_valid, next_wb_valid;
    logic [3:0] wb_reg, next_wb_reg;
    logic [31:0] wb_data, next_wb_data;
    logic bwb_valid, next_bwb_valid;
    logic done, next_done;
    logic unsup, next_unsup;
    logic skipped, next_skipped;
    logic mem_req, next_mem_req;
    logic mem_write, next_mem_write;
    logic [31:0] mem_addr, next_mem_addr;
    logic [31:0] mem_wdata, next_mem_wdata;
    logic [3:0] mem_be, next_mem_be;

    logic [31:0] off_ext;
    logic [31:0] offset_addr;
    logic [31:0] adr_sum;
    logic range_ok;
    logic encoding_ok;
    logic pass;

    always_comb begin
        off_ext = {19'h00000, OFFSET_MAG};
        offset_addr = OFFSET_SUBTRACT ? BASE_VALUE - off_ext : BASE_VALUE + off_ext;
        adr_sum = OFFSET_SUBTRACT ? PROGRAM_COUNTER - off_ext
                                  : PROGRAM_COUNTER + off_ext;
        pass = cond_pass(COND, FLAG_N, FLAG_Z, FLAG_C, FLAG_V);
        range_ok = 1'b1;
        encoding_ok = 1'b1;
        if (OP == PLSU_OP_ADDR) begin
            range_ok = OFFSET_MAG <= ADR_OFFSET_MAX;
            encoding_ok = TRANSFER_REGISTER != REG_STACK_POINTER
                          && TRANSFER_REGISTER != REG_PROGRAM_COUNTER;
        end else if (TWO_WORD_TRANSFER_FORM) begin
            range_ok = OFFSET_MAG <= PAIR_OFFSET_MAX && OFFSET_MAG[1:0] == 2'h0;
            encoding_ok = SIZE == PLSU_SZ_WORD;
        end else if (INDEX_MODE == PLSU_IDX_PLAIN) begin
            range_ok = OFFSET_SUBTRACT ? OFFSET_MAG <= NEG_OFFSET_MAX
                                       : OFFSET_MAG <= PLAIN_OFFSET_MAX;
        end else begin
            range_ok = OFFSET_MAG <= INDEX_OFFSET_MAX;
        end
        if (OP == PLSU_OP_STORE && (SIZE == PLSU_SZ_SBYTE || SIZE == PLSU_SZ_SHALF)) begin
            encoding_ok = 1'b0;
        end
        if (OP != PLSU_OP_ADDR && INDEX_MODE != PLSU_IDX_PLAIN && INDEX_MODE != PLSU_IDX_PRE
            && INDEX_MODE != PLSU_IDX_POST) begin
            encoding_ok = 1'b0;
        end
    end

    assign INSTR_READY = state == PLSU_ST_IDLE;

    always_comb begin
        next_state = state;
        next_is_load = is_load;
        next_pair = pair;
        next_size_q = size_q;
        next_addr_q = addr_q;
        next_data2_q = data2_q;
        next_rt_q = rt_q;
        next_rt2_q = rt2_q;
        next_rn_q = rn_q;
        next_wbase_q = wbase_q;
        next_do_wb_base = do_wb_base;
        next_wb_valid = 1'b0;
        next_wb_reg = wb_reg;
        next_wb_data = wb_data;
        next_bwb_valid = 1'b0;
        next_done = 1'b0;
        next_unsup = 1'b0;
        next_skipped = 1'b0;
        next_mem_req = mem_req;
        next_mem_write = mem_write;
        next_mem_addr = mem_addr;
        next_mem_wdata = mem_wdata;
        next_mem_be = mem_be;
        unique case (state)
            PLSU_ST_IDLE: begin
                if (INSTR_VALID && OP != PLSU_OP_NONE) begin
                    if (!encoding_ok || !range_ok) begin
                        next_done = 1'b1;
                        next_unsup = 1'b1;
                    end else if (!pass) begin
                        next_done = 1'b1;
                        next_skipped = 1'b1;
                    end else if (OP == PLSU_OP_ADDR) begin
                        // Flags are never an output, so they stay as they were
                        next_wb_valid = 1'b1;
                        next_wb_reg = TRANSFER_REGISTER;
                        next_wb_data = adr_sum;
                        next_done = 1'b1;
                    end else begin
                        next_is_load = OP == PLSU_OP_LOAD;
                        next_pair = TWO_WORD_TRANSFER_FORM;
                        next_size_q = SIZE;
                        next_rt_q = TRANSFER_REGISTER;
                        next_rt2_q = SECOND_TRANSFER_REGISTER;
                        next_rn_q = BASE_REGISTER;
                        next_data2_q = SECOND_VALUE;
                        next_wbase_q = offset_addr;
                        next_do_wb_base = INDEX_MODE != PLSU_IDX_PLAIN;
                        next_addr_q = INDEX_MODE == PLSU_IDX_POST ? BASE_VALUE
                            : offset_addr;
                        next_mem_addr = next_addr_q;
                        next_mem_req = 1'b1;
                        next_mem_write = OP == PLSU_OP_STORE;
                        next_mem_be = lane_mask(SIZE, next_addr_q[1:0]);
                        next_mem_wdata = TRANSFER_VALUE << (SIZE == PLSU_SZ_WORD ? 5'h00
                            : SIZE == PLSU_SZ_BYTE ? {next_addr_q[1:0], 3'h0}
                            : {next_addr_q[1], 4'h0});
                        next_state = PLSU_ST_FIRST;
                    end
                end
            end
            PLSU_ST_FIRST: begin
                if (MEM_READY) begin
                    if (is_load) begin
                        next_wb_valid = 1'b1;
                        next_wb_reg = rt_q;
                        next_wb_data = extend_load(size_q, addr_q[1:0], MEM_RDATA);
                    end
                    if (pair) begin
                        // Second word sits at the following word address
                        next_mem_addr = addr_q + WORD_STEP;
                        next_mem_wdata = data2_q;
                        next_mem_be = 4'hf;
                        next_state = PLSU_ST_SECOND;
                    end else begin
                        next_mem_req = 1'b0;
                        next_state = PLSU_ST_DONE;
                    end
                end
            end
            PLSU_ST_SECOND: begin
                if (MEM_READY) begin
                    if (is_load) begin
                        next_wb_valid = 1'b1;
                        next_wb_reg = rt2_q;
                        next_wb_data = MEM_RDATA;
                    end
                    next_mem_req = 1'b0;
                    next_state = PLSU_ST_DONE;
                end
            end
            PLSU_ST_DONE: begin
                next_bwb_valid = do_wb_base;
                next_done = 1'b1;
                next_state = PLSU_ST_IDLE;
            end
            default: next_state = PLSU_ST_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= PLSU_ST_IDLE;
            is_load <= 1'b0;
            pair <= 1'b0;
            size_q <= PLSU_SZ_WORD;
            addr_q <= RESET_WORD;
            data2_q <= RESET_WORD;
            rt_q <= 4'h0;
            rt2_q <= 4'h0;
            rn_q <= 4'h0;
            wbase_q <= RESET_WORD;
            do_wb_base <= 1'b0;
            wb_valid <= 1'b0;
            wb_reg <= 4'h0;
            wb_data <= RESET_WORD;
            bwb_valid <= 1'b0;
            done <= 1'b0;
            unsup <= 1'b0;
            skipped <= 1'b0;
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            mem_addr <= RESET_WORD;
            mem_wdata <= RESET_WORD;
            mem_be <= 4'h0;
        end else begin
            state <= next_state;
            is_load <= next_is_load;
            pair <= next_pair;
            size_q <= next_size_q;
            addr_q <= next_addr_q;
            data2_q <= next_data2_q;
            rt_q <= next_rt_q;
            rt2_q <= next_rt2_q;
            rn_q <= next_rn_q;
            wbase_q <= next_wbase_q;
            do_wb_base <= next_do_wb_base;
            wb_valid <= next_wb_valid;
            wb_reg <= next_wb_reg;
            wb_data <= next_wb_data;
            bwb_valid <= next_bwb_valid;
            done <= next_done;
            unsup <= next_unsup;
            skipped <= next_skipped;
            mem_req <= next_mem_req;
            mem_write <= next_mem_write;
            mem_addr <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
            mem_be <= next_mem_be;
        end
    end

    assign WB_VALID = wb_valid;
    assign WB_REG = wb_reg;
    assign WB_DATA = wb_data;
    assign BASE_WB_VALID = bwb_valid;
    assign BASE_WB_REG = rn_q;
    assign BASE_WB_DATA = wbase_q;
    assign DONE = done;
    assign UNSUPPORTED = unsup;
    assign SKIPPED = skipped;
    assign MEM_REQ = mem_req;
    assign MEM_WRITE = mem_write;
    assign MEM_ADDR = mem_addr;
    assign MEM_WDATA = mem_wdata;
    assign MEM_BYTE_EN = mem_be;
endmodule // plsu_core

// [dv/plsu_core_checker.sv]
// Purpose: Port checks for the address and load/store block
// Assumes: Operands valid at the accept edge
// Notes: Bound into plsu_core, sees its ports only
`timescale 1ns/1ps
module plsu_core_checker (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Instruction
    input wire logic INSTR_VALID,
    input wire logic INSTR_READY,
    input wire plsu_pkg::plsu_op_t OP,
    input wire plsu_pkg::plsu_size_t SIZE,
    input wire plsu_pkg::plsu_index_t INDEX_MODE,
    input wire plsu_pkg::plsu_cond_t COND,
    input wire logic TWO_WORD_TRANSFER_FORM,
    input wire logic OFFSET_SUBTRACT,
    input wire logic [12:0] OFFSET_MAG,
    input wire logic [3:0] TRANSFER_REGISTER,
    input wire logic [31:0] PROGRAM_COUNTER,
    input wire logic [31:0] BASE_VALUE,
    input wire logic FLAG_Z,
    // Results
    input wire logic WB_VALID,
    input wire logic [3:0] WB_REG,
    input wire logic [31:0] WB_DATA,
    input wire logic DONE,
    input wire logic UNSUPPORTED,
    input wire logic SKIPPED,
    // Memory
    input wire logic MEM_REQ,
    input wire logic MEM_WRITE,
    input wire logic [31:0] MEM_ADDR,
    input wire logic [3:0] MEM_BYTE_EN,
    input wire logic MEM_READY
);
    import plsu_pkg::*;
    logic take;
    logic bad_dst;
    logic [31:0] off;
    logic [31:0] pc_sum;
    logic [31:0] first;
    assign take = INSTR_VALID && INSTR_READY && COND == PLSU_CC_AL;
    assign bad_dst = TRANSFER_REGISTER == REG_STACK_POINTER || TRANSFER_REGISTER == 4'hf;
    assign off = {19'h0, OFFSET_MAG};
    assign pc_sum = OFFSET_SUBTRACT ? PROGRAM_COUNTER - off : PROGRAM_COUNTER + off;
    // Post-indexed form reaches memory at the untouched base
    assign first = INDEX_MODE == PLSU_IDX_POST ? BASE_VALUE :
        OFFSET_SUBTRACT ? BASE_VALUE - off : BASE_VALUE + off;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    addr_result_a: assert property (
        take && OP == PLSU_OP_ADDR && !bad_dst && OFFSET_MAG <= ADR_OFFSET_MAX |=> WB_VALID
        && DONE && WB_DATA == $past(pc_sum) && WB_REG == $past(TRANSFER_REGISTER))
        else $error("address result wrong");
    addr_dest_a: assert property (
        take && OP == PLSU_OP_ADDR && bad_dst |=> DONE && UNSUPPORTED && !WB_VALID)
        else $error("bad destination accepted");
    cond_skip_a: assert property (
        INSTR_VALID && INSTR_READY && OP != PLSU_OP_NONE && COND == PLSU_CC_EQ && !FLAG_Z
        |=> DONE && SKIPPED && !WB_VALID && !MEM_REQ)
        else $error("failed condition executed");
    first_addr_a: assert property (
        take && OP inside {PLSU_OP_LOAD, PLSU_OP_STORE} && !TWO_WORD_TRANSFER_FORM
        && OFFSET_MAG <= INDEX_OFFSET_MAX && !(OP == PLSU_OP_STORE && SIZE > PLSU_SZ_HALF)
        |=> MEM_REQ && MEM_ADDR == $past(first))
        else $error("access address wrong");
    req_hold_a: assert property (
        MEM_REQ && !MEM_READY |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WRITE))
        else $error("memory request changed early");
    busy_ready_a: assert property (MEM_REQ |-> !INSTR_READY)
        else $error("ready while busy");
    load_wb_a: assert property (
        MEM_REQ && MEM_READY && !MEM_WRITE |=> WB_VALID)
        else $error("load result not written");
    store_lane_a: assert property (
        MEM_REQ && MEM_WRITE |-> MEM_BYTE_EN inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf})
        else $error("bad store strobes");
    index_range_a: assert property (
        take && OP == PLSU_OP_LOAD && !TWO_WORD_TRANSFER_FORM && INDEX_MODE != PLSU_IDX_PLAIN
        && OFFSET_MAG > INDEX_OFFSET_MAX |=> DONE && UNSUPPORTED && !MEM_REQ)
        else $error("indexed offset range not refused");
endmodule // plsu_core_checker
bind plsu_core plsu_core_checker chk (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .INSTR_VALID(INSTR_VALID), .INSTR_READY(INSTR_READY), .OP(OP), .SIZE(SIZE),
    .INDEX_MODE(INDEX_MODE), .COND(COND), .TWO_WORD_TRANSFER_FORM(TWO_WORD_TRANSFER_FORM),
    .OFFSET_SUBTRACT(OFFSET_SUBTRACT), .OFFSET_MAG(OFFSET_MAG),
    .TRANSFER_REGISTER(TRANSFER_REGISTER), .PROGRAM_COUNTER(PROGRAM_COUNTER),
    .BASE_VALUE(BASE_VALUE), .FLAG_Z(FLAG_Z), .WB_VALID(WB_VALID), .WB_REG(WB_REG),
    .WB_DATA(WB_DATA), .DONE(DONE), .UNSUPPORTED(UNSUPPORTED), .SKIPPED(SKIPPED),
    .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE), .MEM_ADDR(MEM_ADDR),
    .MEM_BYTE_EN(MEM_BYTE_EN), .MEM_READY(MEM_READY));

// [dv/plsu_mem_model.sv]
// Purpose: Data memory answering the block's requests
// Assumes: 256 words, byte lanes by strobe
// Notes: Read data toggles when not answering
`timescale 1ns/1ps
module plsu_mem_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    // Request
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0] mem_byte_en,
    // Answer
    output logic mem_ready,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [256];
    logic [1:0] wait_n;
    initial for (int i = 0; i < 256; i++) mem[i] = 32'h8a7ff080;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ready <= 1'b0;
            wait_n <= 2'h0;
            mem_rdata <= 32'h5a5aa5a5;
        end else if (mem_req && !mem_ready && wait_n >= (slow ? 2'h2 : 2'h0)) begin
            mem_ready <= 1'b1;
            wait_n <= 2'h0;
            mem_rdata <= mem_write ? ~mem_rdata : mem[mem_addr[9:2]];
            for (int b = 0; b < 4; b++) begin
                if (mem_write && mem_byte_en[b]) begin
                    mem[mem_addr[9:2]][8*b +: 8] <= mem_wdata[8*b +: 8];
                end
            end
        end else begin
            mem_ready <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_n <= mem_req && !mem_ready ? wait_n + 2'h1 : 2'h0;
        end
    end
endmodule // plsu_mem_model

// [dv/plsu_core_bench.sv]
// Purpose: Self-checking bench for plsu_core
// Assumes: Memory words start as 8a7ff080
// Notes: Base value scrambled after accept to catch late use
`timescale 1ns/1ps
module plsu_core_bench;
    import plsu_pkg::*;
    typedef struct packed {
        plsu_op_t op; plsu_size_t sz; plsu_index_t ix; logic sub; logic [12:0] mag;
        logic [31:0] data; logic bwb; logic [31:0] bdata;
    } plsu_row_t;
    plsu_row_t rows [9] = '{
        '{PLSU_OP_ADDR, PLSU_SZ_WORD, PLSU_IDX_PLAIN, 1'b0, 13'h0fff, 32'h00001fff, 1'b0, 32'h0},
        '{PLSU_OP_ADDR, PLSU_SZ_WORD, PLSU_IDX_PLAIN, 1'b1, 13'h0fff, 32'h00000001, 1'b0, 32'h0},
        '{PLSU_OP_LOAD, PLSU_SZ_BYTE, PLSU_IDX_PLAIN, 1'b0, 13'h0000, 32'h00000080, 1'b0, 32'h0},
        '{PLSU_OP_LOAD, PLSU_SZ_SBYTE, PLSU_IDX_PLAIN, 1'b0, 13'h0001, 32'hfffffff0, 1'b0, 32'h0},
        '{PLSU_OP_LOAD, PLSU_SZ_HALF, PLSU_IDX_PLAIN, 1'b0, 13'h0002, 32'h00008a7f, 1'b0, 32'h0},
        '{PLSU_OP_LOAD, PLSU_SZ_SHALF, PLSU_IDX_PLAIN, 1'b0, 13'h0000, 32'hfffff080, 1'b0, 32'h0},
        '{PLSU_OP_LOAD, PLSU_SZ_WORD, PLSU_IDX_PRE, 1'b1, 13'h0010, 32'h8a7ff080, 1'b1, 32'hf0},
        '{PLSU_OP_LOAD, PLSU_SZ_WORD, PLSU_IDX_POST, 1'b0, 13'h00ff, 32'h8a7ff080, 1'b1, 32'h1ff},
        '{PLSU_OP_LOAD, PLSU_SZ_WORD, PLSU_IDX_PLAIN, 1'b0, 13'h0ffc, 32'h8a7ff080, 1'b0, 32'h0}};
    logic REF_CLK = 0, RST_N = 0, INSTR_VALID = 0, INSTR_READY, TWO = 0, SUB = 0, FLAG_Z = 0;
    logic slow = 0, WB_VALID, BASE_WB_VALID, DONE, UNSUPPORTED, SKIPPED;
    logic MEM_REQ, MEM_WRITE, MEM_READY, unsup_s, skip_s;
    plsu_op_t OP = PLSU_OP_NONE;
    plsu_size_t SIZE = PLSU_SZ_WORD;
    plsu_index_t IX = PLSU_IDX_PLAIN;
    plsu_cond_t COND = PLSU_CC_AL;
    logic [12:0] MAG = 13'h0;
    logic [3:0] TREG = 4'h1, WB_REG, BASE_WB_REG, MEM_BYTE_EN;
    logic [31:0] BASE = 32'h0, TVAL = 32'h0, SVAL = 32'h0, WB_DATA, BASE_WB_DATA;
    logic [31:0] MEM_ADDR, MEM_WDATA, MEM_RDATA, bwb_d;
    logic [31:0] PC = 32'h00001000;
    logic [31:0] wb_d [2];
    int mismatches = 0, total_checks = 0, wb_n, bwb_n;
    initial forever #12.5 REF_CLK = ~REF_CLK;
    plsu_core uut (.REF_CLK(REF_CLK), .RST_N(RST_N), .INSTR_VALID(INSTR_VALID),
        .INSTR_READY(INSTR_READY), .OP(OP), .SIZE(SIZE), .INDEX_MODE(IX), .COND(COND),
        .TWO_WORD_TRANSFER_FORM(TWO), .OFFSET_SUBTRACT(SUB), .OFFSET_MAG(MAG),
        .TRANSFER_REGISTER(TREG), .SECOND_TRANSFER_REGISTER(4'h2), .BASE_REGISTER(4'h3),
        .PROGRAM_COUNTER(PC), .BASE_VALUE(BASE), .TRANSFER_VALUE(TVAL),
        .SECOND_VALUE(SVAL), .FLAG_N(1'b0), .FLAG_Z(FLAG_Z), .FLAG_C(1'b0), .FLAG_V(1'b0),
        .WB_VALID(WB_VALID), .WB_REG(WB_REG), .WB_DATA(WB_DATA), .BASE_WB_VALID(BASE_WB_VALID),
        .BASE_WB_REG(BASE_WB_REG), .BASE_WB_DATA(BASE_WB_DATA), .DONE(DONE),
        .UNSUPPORTED(UNSUPPORTED), .SKIPPED(SKIPPED), .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE),
        .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_BYTE_EN(MEM_BYTE_EN),
        .MEM_READY(MEM_READY), .MEM_RDATA(MEM_RDATA));
    plsu_mem_model mem (.clk(REF_CLK), .rst_n(RST_N), .slow(slow), .mem_req(MEM_REQ),
        .mem_write(MEM_WRITE), .mem_addr(MEM_ADDR), .mem_wdata(MEM_WDATA),
        .mem_byte_en(MEM_BYTE_EN), .mem_ready(MEM_READY), .mem_rdata(MEM_RDATA));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Issues one instruction, collects write-backs until completion
    task automatic exec(input plsu_op_t op, input plsu_size_t sz, input plsu_index_t ix,
        input logic two, input logic sub, input logic [12:0] mag, input logic [31:0] bv);
        bit got;
        got = 0;
        wb_n = 0;
        bwb_n = 0;
        for (int i = 0; i < 50 && INSTR_READY !== 1'b1; i++) begin
            @(posedge REF_CLK);
            #2;
        end
        OP = op;
        SIZE = sz;
        IX = ix;
        {TWO, SUB, MAG, BASE, INSTR_VALID} = {two, sub, mag, bv, 1'b1};
        @(posedge REF_CLK);
        #2;
        OP = PLSU_OP_NONE;
        {BASE, INSTR_VALID} = {~bv, 1'b0};
        for (int i = 0; i < 50 && !got; i++) begin
            if (WB_VALID === 1'b1 && wb_n < 2) wb_d[wb_n++] = WB_DATA;
            if (BASE_WB_VALID === 1'b1) {bwb_n, bwb_d} = {bwb_n + 1, BASE_WB_DATA};
            if (DONE === 1'b1) {got, unsup_s, skip_s} = {1'b1, UNSUPPORTED, SKIPPED};
            else begin
                @(posedge REF_CLK);
                #2;
            end
        end
        chk("done", {31'h0, got}, 32'h1);
    endtask
    task automatic bad(input plsu_op_t op, input plsu_size_t sz, input plsu_index_t ix,
        input logic sub, input logic [12:0] mag);
        exec(op, sz, ix, 1'b0, sub, mag, 32'h100);
        chk("unsupported", {31'h0, unsup_s}, 32'h1);
        chk("writes", wb_n + bwb_n, 32'h0);
    endtask
    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge REF_CLK);
        #2;
        chk("reset ready", {31'h0, INSTR_READY}, 32'h1);
        chk("reset req", {31'h0, MEM_REQ}, 32'h0);
        repeat (10) @(posedge REF_CLK);
        #2 RST_N = 1;
        foreach (rows[i]) begin
            slow = i[0];
            exec(rows[i].op, rows[i].sz, rows[i].ix, 1'b0, rows[i].sub, rows[i].mag, 32'h100);
            chk("result", wb_d[0], rows[i].data);
            chk("base writes", bwb_n, {31'h0, rows[i].bwb});
            if (rows[i].bwb) chk("new base", bwb_d, rows[i].bdata);
        end
        TREG = REG_STACK_POINTER;
        bad(PLSU_OP_ADDR, PLSU_SZ_WORD, PLSU_IDX_PLAIN, 1'b0, 13'h0004);
        TREG = 4'h1;
        bad(PLSU_OP_ADDR, PLSU_SZ_WORD, PLSU_IDX_PLAIN, 1'b1, 13'h1000);
        bad(PLSU_OP_LOAD, PLSU_SZ_BYTE, PLSU_IDX_PLAIN, 1'b0, 13'h1000);
        bad(PLSU_OP_LOAD, PLSU_SZ_BYTE, PLSU_IDX_PLAIN, 1'b1, 13'h0100);
        bad(PLSU_OP_LOAD, PLSU_SZ_BYTE, PLSU_IDX_PRE, 1'b0, 13'h0100);
        bad(PLSU_OP_STORE, PLSU_SZ_SBYTE, PLSU_IDX_PLAIN, 1'b0, 13'h0000);
        bad(PLSU_OP_STORE, PLSU_SZ_SHALF, PLSU_IDX_PLAIN, 1'b0, 13'h0000);
        COND = PLSU_CC_EQ;
        FLAG_Z = 1'b0;
        exec(PLSU_OP_ADDR, PLSU_SZ_WORD, PLSU_IDX_PLAIN, 1'b0, 1'b0, 13'h0008, 32'h0);
        chk("skip", {31'h0, skip_s}, 32'h1);
        chk("skip writes", wb_n, 32'h0);
        {FLAG_Z, PC} = {1'b1, 32'h00002000};
        exec(PLSU_OP_ADDR, PLSU_SZ_WORD, PLSU_IDX_PLAIN, 1'b0, 1'b0, 13'h0008, 32'h0);
        chk("taken", wb_d[0], 32'h00002008);
        COND = PLSU_CC_AL;
        TVAL = 32'h11223344;
        exec(PLSU_OP_STORE, PLSU_SZ_BYTE, PLSU_IDX_PLAIN, 1'b0, 1'b0, 13'h0003, 32'h200);
        TVAL = 32'h00005566;
        exec(PLSU_OP_STORE, PLSU_SZ_HALF, PLSU_IDX_PLAIN, 1'b0, 1'b0, 13'h0002, 32'h204);
        exec(PLSU_OP_LOAD, PLSU_SZ_WORD, PLSU_IDX_PLAIN, 1'b0, 1'b0, 13'h0000, 32'h200);
        chk("byte lane", wb_d[0], 32'h447ff080);
        exec(PLSU_OP_LOAD, PLSU_SZ_WORD, PLSU_IDX_PLAIN, 1'b0, 1'b0, 13'h0000, 32'h204);
        chk("half lane", wb_d[0], 32'h5566f080);
        {slow, TVAL, SVAL} = {1'b1, 32'haaaa5555, 32'h1234abcd};
        exec(PLSU_OP_STORE, PLSU_SZ_WORD, PLSU_IDX_PRE, 1'b1, 1'b0, 13'h0008, 32'h300);
        chk("pair base", bwb_d, 32'h308);
        exec(PLSU_OP_LOAD, PLSU_SZ_WORD, PLSU_IDX_POST, 1'b1, 1'b1, 13'h0008, 32'h308);
        chk("pair first", wb_d[0], 32'haaaa5555);
        chk("pair second", wb_d[1], 32'h1234abcd);
        chk("pair post base", bwb_d, 32'h300);
        chk("pair reg", {28'h0, WB_REG}, 32'h2);
        chk("base reg", {28'h0, BASE_WB_REG}, 32'h3);
        end_of_test();
    end
endmodule // plsu_core_bench
